// File: design/dbc_regs.sv
// Register bank and control logic of the data-acquisition board
// Overview of operation
// [RULE1] Cal port: one bit per write, bit 7 data, bit 0 clock.
// [RULE2] Two address bits pick the pot: offset, gain, out 0, out 1.
// [RULE3] Each pot holds an 8-bit wiper value, 0 to 255.
// [RULE4] Host sends 2 address bits, 8 value bits MSB first, then 00.
// [RULE5] Host loads calibration once per power-on.
// [RULE6] IRQ select: 0x01 end-of-scan, 0x10 FIFO half, 0x00 none.
// [RULE7] Host enables one interrupt source at most.
// [RULE8] FIFO half event when FIFO reaches half.
// [RULE9] End-of-scan event after the last channel converts.
// [RULE10] Full FIFO pauses storing until a read clears full.
// [RULE11] Input group reads back its pin levels.
// [RULE12] Writing a group makes it output, driving the value.
// [RULE13] Output group reads back the last written value.
// [RULE14] Any direction reset write makes all lines inputs.
// [RULE15] Counter 0 divides 10 MHz by n, 1 < n < 65536.
// [RULE16] Host sets counters 1, 2 to 2.5 us per channel.
// [RULE17] Scan modes run only with scan and acquire enables set.
// [RULE18] Host programs counters 1, 2 before either enable.
// [RULE19] Delayed mode sets acquire enable when trigger goes low.
// [RULE20] Host clears both enables when leaving a scan mode.
// [RULE21] Oversampling picks 1, 2, 8 or 16 samples per channel.
// [RULE22] No oversampling for software or burst conversions.
// [RULE23] Don't-care bits of write-only registers change nothing.
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
module dbc_regs
    import dbc_pkg::*;
#(
    parameter int FIFO_DEPTH = 2048,
    parameter int LW = $clog2(FIFO_DEPTH) + 1
)
(
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic NRST,
    // AXI4-Lite write channels
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    // AXI4-Lite read channels
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // Digital lines, zero is line 0 and fifteen is line 15
    input wire logic [15:0] DIGITAL_LINE_IN,
    output logic [15:0] DIGITAL_LINE_OUT,
    output logic [15:0] DIGITAL_LINE_OE_N,
    // Calibration potentiometers
    output logic CAL_SERIAL_CLOCK,
    output logic CAL_SERIAL_DATA,
    output logic [7:0] POT_ADC_OFFSET,
    output logic [7:0] POT_ADC_GAIN,
    output logic [7:0] POT_OUT0_GAIN,
    output logic [7:0] POT_OUT1_GAIN,
    // Counter 0 output
    output logic CTR0_OUT,
    // Converter and FIFO status from same-clock logic
    input wire logic [LW-1:0] FIFO_LEVEL,
    input wire logic CONV_DONE,
    input wire logic LAST_CHAN,
    input wire logic SOFT_OR_BURST,
    // Delayed external trigger pin, active low
    input wire logic DLY_TRIG_N,
    // Scan control and events
    output logic SCAN_ARMED,
    output logic [1:0] SCAN_SOURCE,
    output logic [4:0] SAMPLES_PER_CHAN,
    output logic STORE_PAUSE,
    output logic FIFO_HALF_IRQ,
    output logic SCAN_DONE_IRQ
);
    localparam logic [LW-1:0] FIFO_FULL_LVL = LW'(FIFO_DEPTH);
    localparam logic [LW-1:0] FIFO_HALF_LVL = LW'(FIFO_DEPTH / 2);

    typedef struct packed {
        // Bus slave
        logic awready;
        logic wready;
        logic arready;
        logic aw_full;
        logic [5:0] aw_idx;
        logic w_full;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        // Calibration write strobe
        logic cal_wr;
        logic [7:0] cal_data;
        // Control registers
        logic eos_en;
        logic dfh_en;
        logic [15:0] dio_val;
        logic [1:0] dio_drv;
        logic [15:0] ctr_div;
        logic scan_en;
        logic acq_en;
        dbc_src_t scan_src;
        logic [1:0] ovs;
        // Pin synchronisers and filtered levels
        logic [15:0] dio_s1;
        logic [15:0] dio_s2;
        logic [15:0] dio_s3;
        logic [15:0] dio_lvl;
        logic trg_s1;
        logic trg_s2;
        logic trg_s3;
        logic trg_lvl;
        // Events and outputs
        logic half_prev;
        logic half_irq;
        logic eos_irq;
        logic pause;
        logic armed;
        logic [4:0] spc;
        logic [4:0] tick_acc;
        logic tick;
        logic [15:0] dio_out;
        logic [15:0] dio_oe_n;
    } dbc_state_t;

    dbc_state_t q_r;
    dbc_state_t q_nxt;
    logic cal_busy;

    // Oversampling code to samples per channel
    function automatic logic [4:0] ovs_samples(input logic [1:0] code);
        logic [4:0] n;
        n = SPC_1;
        unique case (code)
            OVS_1X: n = SPC_1;
            OVS_2X: n = SPC_2;
            OVS_8X: n = SPC_8;
            OVS_16X: n = SPC_16;
        endcase
        return n;
    endfunction

    // Read view of one digital group
    function automatic logic [7:0] dio_read(input logic drv, input logic [7:0] val,
                                           input logic [7:0] pins);
        return drv ? val : pins; // [RULE11] [RULE13]
    endfunction

    // Index decoded by this bank
    function automatic logic idx_mapped(input logic [5:0] idx);
        return idx inside {IDX_CAL, IDX_IRQ, IDX_DLO, IDX_DHI, IDX_CTR, IDX_DRST,
                           IDX_SCAN, IDX_ACQ, IDX_OVS, IDX_STAT, IDX_SRC};
    endfunction

    // All next-state logic
    always_comb
    begin
        logic wr_go;
        logic rd_go;
        logic [7:0] wb;
        logic trg_fall;
        logic half_now;
        logic [5:0] ridx;
        wr_go = 1'b0;
        rd_go = 1'b0;
        wb = 8'h00;
        trg_fall = 1'b0;
        half_now = 1'b0;
        ridx = 6'h00;
        q_nxt = q_r;
        q_nxt.cal_wr = 1'b0;
        q_nxt.half_irq = 1'b0;
        q_nxt.eos_irq = 1'b0;

        // AW and W taken in either order
        if (q_r.awready && S_AXI_AWVALID)
        begin
            q_nxt.aw_full = 1'b1;
            q_nxt.aw_idx = S_AXI_AWADDR[7:2];
        end
        if (q_r.wready && S_AXI_WVALID)
        begin
            q_nxt.w_full = 1'b1;
            q_nxt.w_data = S_AXI_WDATA;
            q_nxt.w_strb = S_AXI_WSTRB;
        end
        if (q_r.bvalid && S_AXI_BREADY)
            q_nxt.bvalid = 1'b0;

        // Write runs once both are held
        if (q_r.aw_full && q_r.w_full && !q_r.bvalid)
        begin
            wr_go = 1'b1;
            q_nxt.aw_full = 1'b0;
            q_nxt.w_full = 1'b0;
            q_nxt.bvalid = 1'b1;
            q_nxt.bresp = idx_mapped(q_r.aw_idx) ? RESP_OKAY : RESP_DECERR;
        end
        wb = q_r.w_data[7:0];

        // Byte regs need lane 0; dir reset takes any write
        if (wr_go && q_r.w_strb[0])
        begin
            unique case (q_r.aw_idx)
                IDX_CAL:
                begin
                    q_nxt.cal_wr = 1'b1; // [RULE1]
                    q_nxt.cal_data = wb;
                end
                IDX_IRQ:
                begin
                    // Only bits 0 and 4 matter
                    q_nxt.eos_en = wb[IRQ_EOS_BIT]; // [RULE6] [RULE23]
                    q_nxt.dfh_en = wb[IRQ_DFH_BIT]; // [RULE6] [RULE23]
                end
                IDX_DLO:
                begin
                    q_nxt.dio_val[7:0] = wb; // [RULE12]
                    q_nxt.dio_drv[0] = 1'b1; // [RULE12]
                end
                IDX_DHI:
                begin
                    q_nxt.dio_val[15:8] = wb; // [RULE12]
                    q_nxt.dio_drv[1] = 1'b1; // [RULE12]
                end
                IDX_CTR: q_nxt.ctr_div[7:0] = wb;
                IDX_SCAN: q_nxt.scan_en = wb[SCAN_EN_BIT]; // [RULE17] [RULE23]
                IDX_ACQ: q_nxt.acq_en = wb[ACQ_EN_BIT]; // [RULE17] [RULE23]
                IDX_OVS: q_nxt.ovs = wb[1:0]; // [RULE21] [RULE23]
                IDX_SRC:
                begin
                    // Code 3 leaves source unchanged
                    if (wb[1:0] != 2'h3)
                        q_nxt.scan_src = dbc_src_t'(wb[1:0]);
                end
                default:
                begin
                end
            endcase
        end
        if (wr_go && q_r.w_strb[1] && q_r.aw_idx == IDX_CTR)
            q_nxt.ctr_div[15:8] = q_r.w_data[15:8]; // [RULE15]
        if (wr_go && q_r.aw_idx == IDX_DRST)
            q_nxt.dio_drv = 2'b00; // [RULE14]

        // One read at a time, answered next cycle
        if (q_r.rvalid && S_AXI_RREADY)
            q_nxt.rvalid = 1'b0;
        if (q_r.arready && S_AXI_ARVALID)
        begin
            rd_go = 1'b1;
            ridx = S_AXI_ARADDR[7:2];
        end
        if (rd_go)
        begin
            q_nxt.rvalid = 1'b1;
            q_nxt.rresp = idx_mapped(ridx) ? RESP_OKAY : RESP_DECERR;
            q_nxt.rdata = 32'h0000_0000;
            unique case (ridx)
                IDX_DLO: q_nxt.rdata[7:0] = dio_read(q_r.dio_drv[0], q_r.dio_val[7:0],
                                                     q_r.dio_lvl[7:0]);
                IDX_DHI: q_nxt.rdata[7:0] = dio_read(q_r.dio_drv[1], q_r.dio_val[15:8],
                                                     q_r.dio_lvl[15:8]);
                IDX_CTR: q_nxt.rdata[15:0] = q_r.ctr_div;
                IDX_SRC: q_nxt.rdata[1:0] = q_r.scan_src;
                IDX_STAT: q_nxt.rdata[7:0] = {cal_busy, q_r.pause, q_r.acq_en,
                                              q_r.scan_en, q_r.dio_drv,
                                              q_r.dfh_en, q_r.eos_en};
                default:
                begin
                end
            endcase
        end

        // Three-stage sync; level counts when 2 and 3 agree
        q_nxt.dio_s1 = DIGITAL_LINE_IN;
        q_nxt.dio_s2 = q_r.dio_s1;
        q_nxt.dio_s3 = q_r.dio_s2;
        for (int i = 0; i < 16; i++)
        begin
            if (q_r.dio_s2[i] == q_r.dio_s3[i])
                q_nxt.dio_lvl[i] = q_r.dio_s3[i];
        end
        q_nxt.trg_s1 = DLY_TRIG_N;
        q_nxt.trg_s2 = q_r.trg_s1;
        q_nxt.trg_s3 = q_r.trg_s2;
        if (q_r.trg_s2 == q_r.trg_s3)
        begin
            q_nxt.trg_lvl = q_r.trg_s3;
            trg_fall = q_r.trg_lvl && !q_r.trg_s3;
        end

        // Hardware set beats host clear
        if (trg_fall && q_r.scan_src == SRC_DELAYED && q_nxt.scan_en)
            q_nxt.acq_en = 1'b1; // [RULE19]

        // FIFO events and store pause
        half_now = (FIFO_LEVEL >= FIFO_HALF_LVL);
        q_nxt.half_prev = half_now;
        q_nxt.half_irq = q_r.dfh_en && half_now && !q_r.half_prev; // [RULE8] [RULE6]
        q_nxt.eos_irq = q_r.eos_en && CONV_DONE && LAST_CHAN; // [RULE9] [RULE6]
        // Level-driven: a read below full resumes storing
        q_nxt.pause = (FIFO_LEVEL >= FIFO_FULL_LVL); // [RULE10]

        // Scan control outputs
        q_nxt.armed = q_nxt.scan_en && q_nxt.acq_en; // [RULE17]
        q_nxt.spc = SOFT_OR_BURST ? SPC_1 : ovs_samples(q_nxt.ovs); // [RULE21] [RULE22]

        // 10 ticks per 25 clocks, uneven but never lost
        if (q_r.tick_acc + TICK_STEP >= TICK_MOD)
        begin
            q_nxt.tick_acc = q_r.tick_acc + TICK_STEP - TICK_MOD;
            q_nxt.tick = 1'b1;
        end
        else
        begin
            q_nxt.tick_acc = q_r.tick_acc + TICK_STEP;
            q_nxt.tick = 1'b0;
        end

        // Pin drivers, enable low
        q_nxt.dio_out = q_nxt.dio_val; // [RULE12]
        q_nxt.dio_oe_n = ~{{8{q_nxt.dio_drv[1]}}, {8{q_nxt.dio_drv[0]}}}; // [RULE12] [RULE14]

        // Registered readies
        q_nxt.awready = !q_nxt.aw_full && !q_nxt.bvalid;
        q_nxt.wready = !q_nxt.w_full && !q_nxt.bvalid;
        q_nxt.arready = !q_nxt.rvalid;
    end

    // State register
    always_ff @(posedge CLK_SYS or negedge NRST)
    begin
        if (!NRST)
        begin
            q_r <= '0;
            q_r.ovs <= OVS_RST;
            q_r.spc <= SPC_1;
            q_r.ctr_div <= CTR_DIV_RST;
            q_r.scan_src <= SRC_TIMED;
            q_r.dio_oe_n <= 16'hFFFF;
            q_r.trg_s1 <= 1'b1;
            q_r.trg_s2 <= 1'b1;
            q_r.trg_s3 <= 1'b1;
            q_r.trg_lvl <= 1'b1;
            q_r.awready <= 1'b1;
            q_r.wready <= 1'b1;
            q_r.arready <= 1'b1;
        end
        else
            q_r <= q_nxt;
    end

    // Calibration loader
    logic [3:0][7:0] pots;
    dbc_cal_loader u_cal (
        .clk(CLK_SYS),
        .nrst(NRST),
        .wr_stb(q_r.cal_wr),
        .wr_data(q_r.cal_data),
        .cal_serial_clock(CAL_SERIAL_CLOCK),
        .cal_serial_data(CAL_SERIAL_DATA),
        .busy(cal_busy),
        .pots(pots)
    );

    // Counter 0 generator
    dbc_freq_gen #(.W(16)) u_ctr0 (
        .clk(CLK_SYS),
        .nrst(NRST),
        .tick(q_r.tick),
        .divisor(q_r.ctr_div),
        .wave(CTR0_OUT)
    );

    // Outputs straight from state
    assign POT_ADC_OFFSET = pots[0];
    assign POT_ADC_GAIN = pots[1];
    assign POT_OUT0_GAIN = pots[2];
    assign POT_OUT1_GAIN = pots[3];
    assign S_AXI_AWREADY = q_r.awready;
    assign S_AXI_WREADY = q_r.wready;
    assign S_AXI_ARREADY = q_r.arready;
    assign S_AXI_BVALID = q_r.bvalid;
    assign S_AXI_BRESP = q_r.bresp;
    assign S_AXI_RVALID = q_r.rvalid;
    assign S_AXI_RRESP = q_r.rresp;
    assign S_AXI_RDATA = q_r.rdata;
    assign DIGITAL_LINE_OUT = q_r.dio_out;
    assign DIGITAL_LINE_OE_N = q_r.dio_oe_n;
    assign SCAN_ARMED = q_r.armed;
    assign SCAN_SOURCE = q_r.scan_src;
    assign SAMPLES_PER_CHAN = q_r.spc;
    assign STORE_PAUSE = q_r.pause;
    assign FIFO_HALF_IRQ = q_r.half_irq;
    assign SCAN_DONE_IRQ = q_r.eos_irq;
endmodule

// File: design/dbc_pkg.sv
// Shared constants and types of the board control register bank
package dbc_pkg;
    // Register indices; byte address is four times
    localparam logic [5:0] IDX_CAL = 6'h0B;
    localparam logic [5:0] IDX_IRQ = 6'h0C;
    localparam logic [5:0] IDX_DLO = 6'h10;
    localparam logic [5:0] IDX_DHI = 6'h11;
    localparam logic [5:0] IDX_CTR = 6'h14;
    localparam logic [5:0] IDX_DRST = 6'h19;
    localparam logic [5:0] IDX_SCAN = 6'h1A;
    localparam logic [5:0] IDX_ACQ = 6'h1E;
    localparam logic [5:0] IDX_OVS = 6'h1F;
    localparam logic [5:0] IDX_STAT = 6'h20;
    localparam logic [5:0] IDX_SRC = 6'h21;
    // Field positions
    localparam int CAL_DATA_BIT = 7;
    localparam int CAL_CLK_BIT = 0;
    localparam int IRQ_EOS_BIT = 0;
    localparam int IRQ_DFH_BIT = 4;
    localparam int SCAN_EN_BIT = 4;
    localparam int ACQ_EN_BIT = 6;
    // Calibration frame: address then value bits
    localparam logic [3:0] CAL_ADDR_BITS = 4'h2;
    localparam logic [3:0] CAL_VAL_BITS = 4'h8;
    localparam logic [3:0] CAL_FRAME_BITS = CAL_ADDR_BITS + CAL_VAL_BITS;
    // Oversampling codes and samples per channel
    localparam logic [1:0] OVS_1X = 2'h1;
    localparam logic [1:0] OVS_2X = 2'h3;
    localparam logic [1:0] OVS_8X = 2'h0;
    localparam logic [1:0] OVS_16X = 2'h2;
    localparam logic [1:0] OVS_RST = OVS_1X;
    localparam logic [4:0] SPC_1 = 5'h01;
    localparam logic [4:0] SPC_2 = 5'h02;
    localparam logic [4:0] SPC_8 = 5'h08;
    localparam logic [4:0] SPC_16 = 5'h10;
    // Reset values
    localparam logic [15:0] CTR_DIV_RST = 16'h0000;
    localparam logic [7:0] POT_RST = 8'h80;
    // Clock rates in MHz; ratio sets tick rate
    localparam int SYS_CLK_MHZ = 25;
    localparam int CTR_CLK_MHZ = 10;
    localparam logic [4:0] TICK_STEP = 5'(CTR_CLK_MHZ);
    localparam logic [4:0] TICK_MOD = 5'(SYS_CLK_MHZ);
    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    // Scan start source
    typedef enum logic [1:0] {SRC_TIMED, SRC_DELAYED, SRC_EXTERNAL} dbc_src_t;
endpackage

// File: design/dbc_cal_loader.sv
// Bit-serial loader for the four calibration potentiometers
module dbc_cal_loader
    import dbc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Write strobe from the register bank
    input wire logic wr_stb,
    input wire logic [7:0] wr_data,
    // Serial lines and pot state
    output logic cal_serial_clock,
    output logic cal_serial_data,
    output logic busy,
    output logic [3:0][7:0] pots
);
    typedef struct packed {
        logic sclk;
        logic sdat;
        logic [3:0] cnt;
        logic [9:0] sh;
        logic [3:0][7:0] pot;
    } dbc_cal_t;

    dbc_cal_t q_r;
    dbc_cal_t q_nxt;

    // Clock-high write shifts, clock-low write ends frame
    always_comb
    begin
        q_nxt = q_r;
        if (wr_stb)
        begin
            q_nxt.sclk = wr_data[CAL_CLK_BIT]; // [RULE1]
            q_nxt.sdat = wr_data[CAL_DATA_BIT]; // [RULE1]
            if (wr_data[CAL_CLK_BIT])
            begin
                // Extra bits past a full frame are dropped
                if (q_r.cnt < CAL_FRAME_BITS)
                begin
                    q_nxt.sh = {q_r.sh[8:0], wr_data[CAL_DATA_BIT]}; // [RULE1]
                    q_nxt.cnt = q_r.cnt + 4'h1;
                end
            end
            else
            begin
                // Short frames are dropped
                if (q_r.cnt == CAL_FRAME_BITS)
                    q_nxt.pot[q_r.sh[9:8]] = q_r.sh[7:0]; // [RULE2] [RULE3]
                q_nxt.cnt = 4'h0;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            q_r <= '{sclk: 1'b0, sdat: 1'b0, cnt: 4'h0, sh: 10'h000,
                     pot: {4{POT_RST}}};
        else
            q_r <= q_nxt;
    end

    assign cal_serial_clock = q_r.sclk;
    assign cal_serial_data = q_r.sdat;
    assign busy = (q_r.cnt != 4'h0);
    assign pots = q_r.pot;
endmodule

// File: design/dbc_freq_gen.sv
// Counter 0 frequency generator: divides the counter tick by n
module dbc_freq_gen
    import dbc_pkg::*;
#(
    parameter int W = 16
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Counter clock enable and divisor
    input wire logic tick,
    input wire logic [W-1:0] divisor,
    // Divided output
    output logic wave
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic wave;
    } dbc_fg_t;

    dbc_fg_t q_r;
    dbc_fg_t q_nxt;

    // Period of n ticks; n below 2 holds low
    always_comb
    begin
        q_nxt = q_r;
        if (divisor < W'(2))
        begin
            q_nxt.cnt = '0;
            q_nxt.wave = 1'b0;
        end
        else if (tick)
        begin
            q_nxt.cnt = (q_r.cnt == '0) ? divisor - W'(1) : q_r.cnt - W'(1); // [RULE15]
            q_nxt.wave = (q_nxt.cnt >= (divisor >> 1)); // [RULE15]
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            q_r <= '{cnt: '0, wave: 1'b0};
        else
            q_r <= q_nxt;
    end

    assign wave = q_r.wave;
endmodule

// File: sim/dbc_regs_properties.sv
// Concurrent checks on the ports of the board control register bank
module dbc_regs_chk
    import dbc_pkg::*;
#(
    parameter int FIFO_DEPTH = 2048,
    parameter int LW = 12
)
(
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic NRST,
    // Converter and FIFO status
    input wire logic [LW-1:0] FIFO_LEVEL,
    input wire logic CONV_DONE,
    input wire logic LAST_CHAN,
    input wire logic SOFT_OR_BURST,
    // Outputs under watch
    input wire logic STORE_PAUSE,
    input wire logic FIFO_HALF_IRQ,
    input wire logic SCAN_DONE_IRQ,
    input wire logic [4:0] SAMPLES_PER_CHAN,
    input wire logic [15:0] DIGITAL_LINE_OE_N,
    input wire logic CAL_SERIAL_CLOCK,
    input wire logic [7:0] POT_ADC_OFFSET,
    input wire logic [7:0] POT_ADC_GAIN,
    input wire logic [7:0] POT_OUT0_GAIN,
    input wire logic [7:0] POT_OUT1_GAIN
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!NRST);
    localparam int HALF = FIFO_DEPTH / 2;
    sequence s_full;
        FIFO_LEVEL >= FIFO_DEPTH;
    endsequence
    // Pause lags full by one edge
    AST_PAUSE_SET: assert property (s_full |=> STORE_PAUSE)
        else $error("no pause");
    AST_PAUSE_CLR: assert property (FIFO_LEVEL < FIFO_DEPTH |=> !STORE_PAUSE)
        else $error("pause kept");
    // Half event only after an upward crossing
    AST_HALF_CAUSE: assert property (FIFO_HALF_IRQ |-> $past(FIFO_LEVEL) >= HALF
        && $past(FIFO_LEVEL, 2) < HALF) else $error("half without crossing");
    AST_EOS_CAUSE: assert property (SCAN_DONE_IRQ |-> $past(CONV_DONE && LAST_CHAN))
        else $error("stray scan end");
    AST_EOS_MID: assert property (CONV_DONE && !LAST_CHAN |=> !SCAN_DONE_IRQ)
        else $error("scan end mid scan");
    AST_SPC_SOFT: assert property (SOFT_OR_BURST |=> SAMPLES_PER_CHAN == 5'h01)
        else $error("oversampled soft");
    AST_SPC_CODE: assert property (SAMPLES_PER_CHAN inside {5'h01, 5'h02,
        5'h08, 5'h10}) else $error("bad samples");
    // Whole groups of eight
    AST_OE_GROUP: assert property (DIGITAL_LINE_OE_N[7:0] inside {8'h00, 8'hFF}
        && DIGITAL_LINE_OE_N[15:8] inside {8'h00, 8'hFF}) else $error("split group");
    // Pots change only on the end write
    AST_POT_END: assert property ($changed({POT_ADC_OFFSET, POT_ADC_GAIN, POT_OUT0_GAIN,
        POT_OUT1_GAIN}) |-> !CAL_SERIAL_CLOCK) else $error("pot changed mid frame");
endmodule
bind dbc_regs dbc_regs_chk #(.FIFO_DEPTH(FIFO_DEPTH), .LW(LW)) u_chk (.*);

// File: sim/dbc_pin_model.sv
// Field-side model of the sixteen digital lines
module dbc_pin_model
(
    // Field source and board drive
    input wire logic [15:0] ext_drive,
    input wire logic [15:0] board_out,
    input wire logic [15:0] board_oe_n,
    // Resolved wire level
    output logic [15:0] wire_level
);
    timeunit 1ns;
    timeprecision 1ps;
    // Board wins where it drives, field source elsewhere
    assign wire_level = (board_oe_n & ext_drive) | (~board_oe_n & board_out);
endmodule

// File: sim/dbc_regs_tb.sv
// Self-checking bench of the board control register bank
module dbc_regs_tb
    import dbc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLK_SYS = 0, NRST = 0, S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0;
    logic S_AXI_ARVALID = 0, S_AXI_RREADY = 0, CONV_DONE = 0, LAST_CHAN = 0;
    logic SOFT_OR_BURST = 0, DLY_TRIG_N = 1;
    logic [7:0] S_AXI_AWADDR = 0, S_AXI_ARADDR = 0;
    logic [31:0] S_AXI_WDATA = 0, S_AXI_RDATA, d, v;
    logic [3:0] S_AXI_WSTRB = 4'hF;
    logic [11:0] FIFO_LEVEL = 0;
    logic [15:0] DIGITAL_LINE_IN, DIGITAL_LINE_OUT, DIGITAL_LINE_OE_N, ext = 0;
    logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
    logic CAL_SERIAL_CLOCK, CAL_SERIAL_DATA, CTR0_OUT, SCAN_ARMED, STORE_PAUSE;
    logic FIFO_HALF_IRQ, SCAN_DONE_IRQ;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP, SCAN_SOURCE, r;
    logic [4:0] SAMPLES_PER_CHAN;
    logic [7:0] POT_ADC_OFFSET, POT_ADC_GAIN, POT_OUT0_GAIN, POT_OUT1_GAIN;
    int fail_count = 0, cmp_count = 0, seed = 81, n_eos = 0, n_dfh = 0, n_ctr = 0, e0, h0;
    int pot[4] = '{128, 128, 128, 128};
    always #20 CLK_SYS = ~CLK_SYS;
    dbc_regs uut (.*);
    dbc_pin_model u_pins (.ext_drive(ext), .board_out(DIGITAL_LINE_OUT),
        .board_oe_n(DIGITAL_LINE_OE_N), .wire_level(DIGITAL_LINE_IN));
    // Event pulse and divider edge tallies
    always @(posedge CLK_SYS)
    begin
        n_eos <= n_eos + SCAN_DONE_IRQ;
        n_dfh <= n_dfh + FIFO_HALF_IRQ;
    end
    always @(posedge CTR0_OUT) n_ctr++;
    task tick(input int n);
        repeat (n) @(posedge CLK_SYS);
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    // Write, both halves offered together
    task wr(input logic [5:0] i, input logic [31:0] x);
        bit a, w;
        a = 0;
        w = 0;
        S_AXI_AWADDR <= {i, 2'b00};
        S_AXI_WDATA <= x;
        S_AXI_AWVALID <= 1;
        S_AXI_WVALID <= 1;
        while (!(a && w))
        begin
            tick(1);
            a = a | S_AXI_AWREADY;
            w = w | S_AXI_WREADY;
            S_AXI_AWVALID <= !a;
            S_AXI_WVALID <= !w;
        end
        S_AXI_BREADY <= 1;
        do tick(1); while (S_AXI_BVALID !== 1'b1);
        r = S_AXI_BRESP;
        S_AXI_BREADY <= 0;
    endtask
    task rd(input logic [5:0] i);
        S_AXI_ARADDR <= {i, 2'b00};
        S_AXI_ARVALID <= 1;
        do tick(1); while (S_AXI_ARREADY !== 1'b1);
        S_AXI_ARVALID <= 0;
        S_AXI_RREADY <= 1;
        do tick(1); while (S_AXI_RVALID !== 1'b1);
        d = S_AXI_RDATA;
        r = S_AXI_RRESP;
        S_AXI_RREADY <= 0;
    endtask
    // Pot frame of nb bits, junk in don't-cares
    task cal(input int p, input int x, input int nb);
        int f;
        f = (p << 8) | x;
        for (int k = 9; k > 9 - nb; k--)
            wr(IDX_CAL, {24'h0, 1'(f >> k), 6'($random(seed)), 1'b1});
        wr(IDX_CAL, 32'h0);
        if (nb == 10)
            pot[p] = x;
    endtask
    task wrap_up;
        $display("Checks %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // About 1.5k cycles needed; wide margin
    initial
    begin
        #2000000;
        fail_count++;
        wrap_up();
    end
    initial
    begin
        tick(20);
        NRST <= 1;
        tick(1);
        chk(DIGITAL_LINE_OE_N, 16'hFFFF);
        // Full frame, then a dropped short one
        for (int p = 0; p < 4; p++)
        begin
            cal(p, p == 3 ? 255 : $random(seed) & 255, 10);
            cal(p, 255 - pot[p], 7);
            tick(3);
            chk({POT_ADC_OFFSET, POT_ADC_GAIN, POT_OUT0_GAIN, POT_OUT1_GAIN},
                {8'(pot[0]), 8'(pot[1]), 8'(pot[2]), 8'(pot[3])});
        end
        ext <= 16'($random(seed));
        tick(8);
        for (int g = 0; g < 2; g++)
        begin
            rd(IDX_DLO + 6'(g));
            chk(d, ext[8*g +: 8]);
            v = $random(seed);
            wr(IDX_DLO + 6'(g), v);
            tick(2);
            chk(DIGITAL_LINE_OE_N[8*g +: 8], 8'h00);
            chk(DIGITAL_LINE_OUT[8*g +: 8], v[7:0]);
            rd(IDX_DLO + 6'(g));
            chk(d, v[7:0]);
        end
        wr(IDX_DRST, $random(seed));
        tick(8);
        chk(DIGITAL_LINE_OE_N, 16'hFFFF);
        rd(IDX_DHI);
        chk(d, ext[15:8]);
        // One source at a time against both events
        for (int c = 0; c < 3; c++)
        begin
            e0 = n_eos;
            h0 = n_dfh;
            wr(IDX_IRQ, (c == 0 ? 1 : c == 1 ? 16 : 0) | ($random(seed) & 8'hEE));
            CONV_DONE <= 1;
            tick(1);
            LAST_CHAN <= 1;
            tick(1);
            CONV_DONE <= 0;
            FIFO_LEVEL <= 12'd1023;
            tick(1);
            FIFO_LEVEL <= 12'd2048;
            tick(2);
            chk(STORE_PAUSE, 1'b1);
            FIFO_LEVEL <= 12'd2047;
            tick(2);
            chk(STORE_PAUSE, 1'b0);
            FIFO_LEVEL <= 0;
            tick(3);
            chk(n_eos - e0, c == 0);
            chk(n_dfh - h0, c == 1);
        end
        for (int k = 0; k < 4; k++)
        begin
            wr(IDX_SCAN, ((k & 1) << 4) | ($random(seed) & 32'hEF));
            wr(IDX_ACQ, ((k >> 1) << 6) | ($random(seed) & 32'hBF));
            tick(2);
            chk(SCAN_ARMED, k == 3);
        end
        wr(IDX_ACQ, 0);
        wr(IDX_SRC, 1);
        DLY_TRIG_N <= 0;
        tick(8);
        chk(SCAN_ARMED, 1'b1);
        DLY_TRIG_N <= 1;
        wr(IDX_SCAN, 0);
        wr(IDX_ACQ, 0);
        for (int k = 0; k < 4; k++)
        begin
            wr(IDX_OVS, k | ($random(seed) & 32'hFC));
            tick(2);
            chk(SAMPLES_PER_CHAN, k == 0 ? 8 : k == 1 ? 1 : k == 2 ? 16 : 2);
            SOFT_OR_BURST <= 1;
            tick(2);
            chk(SAMPLES_PER_CHAN, 1);
            SOFT_OR_BURST <= 0;
        end
        wr(6'h3F, 0);
        chk(r, RESP_DECERR);
        rd(6'h3F);
        chk(r, RESP_DECERR);
        // 1000 clocks hold 400 ticks, so 80 periods of n = 5
        wr(IDX_CTR, 5);
        e0 = n_ctr;
        tick(1000);
        chk(n_ctr - e0 >= 79 && n_ctr - e0 <= 81, 1);
        wrap_up();
    end
endmodule
